//--- hw/pwo_pkg.sv
// Purpose: shared constants and types for the PWM output stage
// Assumes: APB byte address is four times the register index
// Notes:   all registers are eight bits wide, upper bus bits read zero
package pwo_pkg;
	localparam int NCH    = 6;
	localparam int NPAIR  = 3;
	localparam int ADDR_W = 12;
	localparam int DT_W   = 9;
	localparam int CNT_W  = 16;

	// register indices
	localparam logic [7:0] IDX_POL   = 8'hd6;
	localparam logic [7:0] IDX_BRK   = 8'hd7;
	localparam logic [7:0] IDX_CTL0  = 8'hd8;
	localparam logic [7:0] IDX_CTL1  = 8'hdf;
	localparam logic [7:0] IDX_TA    = 8'hc7;
	localparam logic [7:0] IDX_DTEN  = 8'hf9;
	localparam logic [7:0] IDX_DTCNT = 8'hfa;
	localparam logic [7:0] IDX_MEN   = 8'hfb;
	localparam logic [7:0] IDX_MLV   = 8'hfc;

	// reset values and writable bits
	localparam logic [7:0] REG_RST   = 8'h00;
	localparam logic [7:0] MASK_CH   = 8'h3f;
	localparam logic [7:0] MASK_DTEN = 8'h17;
	localparam logic [7:0] MASK_BRK  = 8'h7f;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

	// unlock keys
	localparam logic [7:0] TA_KEY1 = 8'haa;
	localparam logic [7:0] TA_KEY2 = 8'h55;

	// field positions
	localparam int BIT_RUN  = 7;
	localparam int BIT_FLAG = 7;
	localparam int BIT_EDGE = 6;
	localparam int BIT_DT8  = 4;

	localparam int DEBOUNCE_CYC = 8;

	typedef enum logic [1:0] {
		PWO_MODE_INDEP = 2'b00,
		PWO_MODE_COMPL = 2'b01,
		PWO_MODE_SYNC  = 2'b10,
		PWO_MODE_RSVD  = 2'b11
	} pwo_mode_e;

	typedef struct packed {
		pwo_mode_e  mode;
		logic       group;
		logic       center;
		logic       pin_en;
		logic [2:0] clk_div;
	} pwo_ctl1_s;

	typedef enum logic [1:0] {
		PWO_TA_LOCKED = 2'b00,
		PWO_TA_KEY1   = 2'b01,
		PWO_TA_OPEN   = 2'b10
	} pwo_ta_e;
endpackage

//--- hw/pwo_deadtime.sv
// Purpose: dead-time insertion for one complementary channel pair
// Assumes: tick is a one-cycle enable at the PWM clock rate
// Notes:   holds back any 0-to-1 edge until the down-counter underflows
`timescale 1ns/1ps
module pwo_deadtime #(
	parameter int W = 9
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// control
	input  wire logic         tick,
	input  wire logic         enable,
	input  wire logic [W-1:0] len,
	// pair signals
	input  wire logic         sig_a,
	input  wire logic         sig_b,
	output logic              out_a,
	output logic              out_b
);
	logic         prev_a;
	logic         prev_b;
	logic         busy;
	logic [W-1:0] cnt;
	logic         rise;
	logic         hold;

	if (W < 2) begin : g_bad_width
		$error("dead-time width too small");
	end

	assign rise = (sig_a & ~prev_a) | (sig_b & ~prev_b);
	// covers the edge cycle itself, before busy is up
	assign hold = busy | (rise & enable);
	assign out_a = sig_a & ~hold; // [RULE_01] [RULE_20]
	assign out_b = sig_b & ~hold; // [RULE_01] [RULE_20]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
		end else begin
			prev_a <= sig_a;
			prev_b <= sig_b;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			cnt  <= '0;
		end else if (!enable) begin
			busy <= 1'b0;
		end else if (rise) begin
			busy <= 1'b1; // [RULE_23]
			cnt  <= len;
		end else if (busy && tick) begin
			if (cnt == '0) begin
				busy <= 1'b0; // [RULE_23]
			end else begin
				cnt <= cnt - 1'b1;
			end
		end
	end

	a_dt_reload: assert property ( // [RULE_23] [RULE_20]
		@(posedge pclk) disable iff (!presetn)
		rise && enable |=> busy && cnt == $past(len))
		else $error("dead-time counter not reloaded on a rising edge");
endmodule

//--- hw/pwo_output_stage.sv
// Purpose: six-channel PWM output stage with brake and dead time
// Assumes: raw signals and tick come from the generator on pclk
// Notes:   brake pin is asynchronous and passes a two-stage synchroniser
`timescale 1ns/1ps

// Behaviour
// [RULE_01] per-pair dead-time enable delays rising edges
// [RULE_02] dead-time enable honoured only in complementary mode
// [RULE_03] dead-time length is nine bits, msb separate
// [RULE_04] counter used only for enabled complementary pairs
// [RULE_05] dead-time registers need unlock before writing
// [RULE_06] synchronous mode copies even channel to odd
// [RULE_07] mask enable replaces channel with mask level
// [RULE_08] mask level bit forces low or high
// [RULE_09] polarity also inverts the forced mask level
// [RULE_10] brake pin acts only when pin enabled
// [RULE_11] brake drives channels to brake levels
// [RULE_12] brake clears run and resets counter
// [RULE_13] brake sets flag; only software clears it
// [RULE_14] brake levels hold until run set again
// [RULE_15] edge select picks falling or rising fault
// [RULE_16] brake pin debounced over eight clocks
// [RULE_17] comparator event brakes exactly like the pin
// [RULE_18] polarity bit inverts the pin output
// [RULE_19] complementary mode odd channel inverts even
// [RULE_20] rising edges held until counter underflows
// [RULE_21] mode field: independent, complementary, synchronous
// [RULE_22] order: mode, dead time, mask, brake, polarity
// [RULE_23] counter reloads on rise, counts per tick
module pwo_output_stage
	import pwo_pkg::*;
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// generator link
	input  wire logic [NCH-1:0]    raw_generator_signal,
	input  wire logic              pwm_tick,
	output logic                   generator_run,
	output logic                   counter_reset,
	output logic      [CNT_W-1:0]  counter_load_value,
	output pwo_ctl1_s              pwm_control_1,
	// fault sources
	input  wire logic              brake_input_pin,
	input  wire logic              adc_cmp_event,
	output logic                   brake_flag,
	output logic                   brake_active,
	// output pins
	output logic      [NCH-1:0]    pwm_pin
);
	logic [7:0]     output_polarity_invert;
	logic [6:0]     brake_data;
	logic [7:0]     deadtime_enable;
	logic [7:0]     deadtime_length;
	logic [7:0]     mask_enable;
	logic [7:0]     mask_level;
	pwo_ta_e        ta_state;
	logic [7:0]     idx;
	logic           addr_ok;
	logic           hit;
	logic           wr;
	logic [7:0]     rd_mux;
	logic [DT_W-1:0] dt_len;
	logic           pin_s1;
	logic           pin_s2;
	logic           pin_filt;
	logic [3:0]     deb_cnt;
	logic [2:0]     warm;
	logic           pin_ev;
	logic           brk_ev;
	logic           brk_now;
	logic [NCH-1:0] mode_out;
	logic [NCH-1:0] dt_out;
	logic [NCH-1:0] next_pin;
	logic [NPAIR-1:0] dt_on;

	// apb decode; zero wait states, so every access ends in one cycle
	assign pready  = 1'b1;
	assign idx     = paddr[9:2];
	assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
	assign wr      = psel && penable && pwrite && hit;
	assign pslverr = psel && penable && !hit;
	assign counter_load_value = CNT_ZERO; // [RULE_12]

	always_comb begin
		hit    = addr_ok;
		rd_mux = REG_RST;
		case (idx)
			IDX_POL:   rd_mux = output_polarity_invert;
			IDX_BRK:   rd_mux = {brake_flag, brake_data};
			IDX_CTL0:  rd_mux = {generator_run, 7'h00};
			IDX_CTL1:  rd_mux = pwm_control_1;
			IDX_TA:    rd_mux = {7'h00, ta_state == PWO_TA_OPEN};
			IDX_DTEN:  rd_mux = deadtime_enable;
			IDX_DTCNT: rd_mux = deadtime_length;
			IDX_MEN:   rd_mux = mask_enable;
			IDX_MLV:   rd_mux = mask_level;
			default:   hit    = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= hit ? {24'h00_0000, rd_mux} : 32'h0000_0000;
		end
	end

	// timed access: two keys open one protected write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ta_state <= PWO_TA_LOCKED;
		end else if (wr) begin
			case (ta_state)
				PWO_TA_LOCKED: begin
					if (idx == IDX_TA && pwdata[7:0] == TA_KEY1) begin
						ta_state <= PWO_TA_KEY1;
					end
				end
				PWO_TA_KEY1: begin
					if (idx == IDX_TA && pwdata[7:0] == TA_KEY2) begin
						ta_state <= PWO_TA_OPEN;
					end else begin
						ta_state <= PWO_TA_LOCKED;
					end
				end
				// any write to a mapped register closes the window again
				PWO_TA_OPEN: ta_state <= PWO_TA_LOCKED; // [RULE_05]
				default:     ta_state <= PWO_TA_LOCKED;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deadtime_enable <= REG_RST;
			deadtime_length <= REG_RST;
		end else if (wr && ta_state == PWO_TA_OPEN) begin // [RULE_05]
			if (idx == IDX_DTEN) begin
				deadtime_enable <= pwdata[7:0] & MASK_DTEN;
			end
			if (idx == IDX_DTCNT) begin
				deadtime_length <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_polarity_invert <= REG_RST; // [RULE_18]
			mask_enable            <= REG_RST; // [RULE_07]
			mask_level             <= REG_RST;
			pwm_control_1          <= REG_RST; // [RULE_21]
			brake_data             <= REG_RST[6:0];
		end else if (wr) begin
			case (idx)
				IDX_POL:  output_polarity_invert <= pwdata[7:0] & MASK_CH;
				IDX_MEN:  mask_enable <= pwdata[7:0] & MASK_CH;
				IDX_MLV:  mask_level  <= pwdata[7:0] & MASK_CH;
				IDX_CTL1: pwm_control_1 <= pwdata[7:0];
				IDX_BRK:  brake_data  <= pwdata[6:0] & MASK_BRK[6:0];
				default:  ;
			endcase
		end
	end

	// brake pin: synchronise, then debounce
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			warm   <= 3'b000;
		end else begin
			pin_s1 <= brake_input_pin;
			pin_s2 <= pin_s1;
			warm   <= {warm[1:0], 1'b1};
		end
	end

	// filter preloads once the synchroniser holds the real level,
	// so a pin idling high never looks like an edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_filt <= 1'b0;
			deb_cnt  <= 4'h0;
			pin_ev   <= 1'b0;
		end else begin
			pin_ev <= 1'b0;
			if (warm == 3'b011) begin
				pin_filt <= pin_s2;
				deb_cnt  <= 4'h0;
			end else if (pin_s2 == pin_filt) begin
				deb_cnt <= 4'h0;
			end else if (deb_cnt == 4'(DEBOUNCE_CYC - 1)) begin // [RULE_16]
				pin_filt <= pin_s2;
				deb_cnt  <= 4'h0;
				pin_ev   <= (pin_s2 == brake_data[BIT_EDGE]); // [RULE_15]
			end else begin
				deb_cnt <= deb_cnt + 4'h1;
			end
		end
	end

	assign brk_ev  = (pin_ev && pwm_control_1.pin_en) // [RULE_10]
		|| adc_cmp_event; // [RULE_17]
	assign brk_now = brake_active || brk_ev;

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brake_flag <= 1'b0;
		end else if (brk_ev) begin
			brake_flag <= 1'b1; // [RULE_13]
		end else if (wr && idx == IDX_BRK && !pwdata[BIT_FLAG]) begin
			brake_flag <= 1'b0; // [RULE_13]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			generator_run <= 1'b0;
			brake_active  <= 1'b0;
			counter_reset <= 1'b0;
		end else begin
			counter_reset <= brk_ev; // [RULE_12]
			if (brk_ev) begin
				generator_run <= 1'b0; // [RULE_12]
				brake_active  <= 1'b1;
			end else if (wr && idx == IDX_CTL0) begin
				generator_run <= pwdata[BIT_RUN];
				if (pwdata[BIT_RUN]) begin
					brake_active <= 1'b0; // [RULE_14]
				end
			end
		end
	end

	// mode stage and dead time per pair
	assign dt_len = {deadtime_enable[BIT_DT8], deadtime_length}; // [RULE_03]

	for (genvar p = 0; p < NPAIR; p++) begin : g_pair
		always_comb begin
			mode_out[2*p] = raw_generator_signal[2*p];
			case (pwm_control_1.mode)
				PWO_MODE_COMPL: begin
					mode_out[2*p+1] = ~raw_generator_signal[2*p]; // [RULE_19]
				end
				PWO_MODE_SYNC: begin
					mode_out[2*p+1] = raw_generator_signal[2*p]; // [RULE_06]
				end
				default: begin
					mode_out[2*p+1] = raw_generator_signal[2*p+1];
				end
			endcase
		end

		assign dt_on[p] = deadtime_enable[p] // [RULE_02] [RULE_04]
			&& pwm_control_1.mode == PWO_MODE_COMPL;

		pwo_deadtime #(
			.W (DT_W)
		) u_dt (
			.pclk    (pclk),
			.presetn (presetn),
			.tick    (pwm_tick),
			.enable  (dt_on[p]),
			.len     (dt_len),
			.sig_a   (mode_out[2*p]),
			.sig_b   (mode_out[2*p+1]),
			.out_a   (dt_out[2*p]),
			.out_b   (dt_out[2*p+1])
		);
	end

	// mask, then brake, then polarity: brake must beat the mask
	for (genvar c = 0; c < NCH; c++) begin : g_chan
		logic masked;
		logic braked;
		assign masked = mask_enable[c] ? mask_level[c] : dt_out[c]; // [RULE_08]
		assign braked = brk_now ? brake_data[c] : masked; // [RULE_11] [RULE_22]
		assign next_pin[c] = braked ^ output_polarity_invert[c]; // [RULE_09]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_pin <= '0;
		end else begin
			pwm_pin <= next_pin; // [RULE_18]
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_brake;
		brk_ev;
	endsequence

	sequence s_locked_dt_write;
		wr && (idx == IDX_DTEN || idx == IDX_DTCNT)
			&& ta_state != PWO_TA_OPEN;
	endsequence

	a_brake_flag_set: assert property ( // [RULE_13]
		s_brake |=> brake_flag)
		else $error("brake did not set the flag");

	a_run_and_count: assert property ( // [RULE_12]
		s_brake |=> !generator_run && counter_reset ##1 !counter_reset)
		else $error("brake did not stop run or pulse counter reset");

	a_brake_hold: assert property ( // [RULE_14]
		brake_active && !(wr && idx == IDX_CTL0 && pwdata[BIT_RUN])
			|=> brake_active)
		else $error("brake released without run being set");

	a_brake_levels: assert property ( // [RULE_11]
		s_brake |=> pwm_pin == $past(brake_data[5:0]
			^ output_polarity_invert[5:0]))
		else $error("pins do not show brake levels");

	a_pin_disabled: assert property ( // [RULE_10]
		pin_ev && !pwm_control_1.pin_en && !adc_cmp_event
			|=> !$rose(brake_flag))
		else $error("disabled brake pin caused a brake");

	a_adc_brake: assert property ( // [RULE_17]
		adc_cmp_event |=> brake_flag && brake_active && !generator_run)
		else $error("comparator event did not brake");

	a_debounce_len: assert property ( // [RULE_16]
		$past(warm) == 3'b111 && $changed(pin_filt)
			|-> $past(deb_cnt) == 4'(DEBOUNCE_CYC - 1))
		else $error("brake filter changed before eight clocks");

	a_mask_level: assert property ( // [RULE_08] [RULE_09]
		!brk_now && mask_enable[0]
			|=> pwm_pin[0] == $past(mask_level[0]
				^ output_polarity_invert[0]))
		else $error("masked channel shows wrong level");

	a_sync_copy: assert property ( // [RULE_06]
		pwm_control_1.mode == PWO_MODE_SYNC && !brk_now
			&& mask_enable[1:0] == 2'b00
			|=> (pwm_pin[1] ^ $past(output_polarity_invert[1]))
				== (pwm_pin[0] ^ $past(output_polarity_invert[0])))
		else $error("odd channel is not an in-phase copy");

	a_ta_lock: assert property ( // [RULE_05]
		s_locked_dt_write |=> $stable(deadtime_enable)
			&& $stable(deadtime_length))
		else $error("locked dead-time register was written");
endmodule

//--- tb/pwo_half_bridge.sv
// Purpose: half-bridge switch legs driven by the six pins
// Assumes: a high pin level turns its switch on
// Notes:   counts cycles where both switches of one leg conduct
`timescale 1ns/1ps
module pwo_half_bridge
	import pwo_pkg::*;
(
	// clock and reset
	input  wire logic           pclk,
	input  wire logic           presetn,
	// gate drives
	input  wire logic [NCH-1:0] gate,
	// shoot-through watch
	output logic      [15:0]    shoot_cnt
);
	logic overlap;

	// any overlap would short the supply through one leg
	assign overlap = (gate[0] & gate[1]) | (gate[2] & gate[3])
		| (gate[4] & gate[5]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shoot_cnt <= 16'h0000;
		end else if (overlap) begin
			shoot_cnt <= shoot_cnt + 16'h0001;
		end
	end
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench for the PWM output stage
// Assumes: byte address is four times the register index
// Notes:   pins are sampled on the falling edge, bus answers on the rising
`timescale 1ns/1ps
module testbench;
	import pwo_pkg::*;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0;
	logic [NCH-1:0]    raw = '0;
	logic              tick = 1'b1;
	logic              tick_slow = 1'b0;
	logic              fb_pin = 1'b0;
	logic              adc_ev = 1'b0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              run;
	logic              cnt_rst;
	logic              flag;
	logic              brk;
	logic [CNT_W-1:0]  cnt_val;
	pwo_ctl1_s         ctl1;
	logic [NCH-1:0]    pin;
	logic [15:0]       shoot;
	logic [NCH:0]      obs;
	int                error_cnt = 0;
	int                checks_done = 0;

	assign obs = {flag, pin};

	always #5 pclk = ~pclk;

	// half-rate tick on demand shows the counter is paced by tick
	always @(posedge pclk)
		tick <= tick_slow ? ~tick : 1'b1;

	pwo_output_stage i_pwo_output_stage (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .raw_generator_signal(raw),
		.pwm_tick(tick), .generator_run(run), .counter_reset(cnt_rst),
		.counter_load_value(cnt_val), .pwm_control_1(ctl1),
		.brake_input_pin(fb_pin), .adc_cmp_event(adc_ev),
		.brake_flag(flag), .brake_active(brk), .pwm_pin(pin)
	);

	pwo_half_bridge i_pwo_half_bridge (
		.pclk(pclk), .presetn(presetn), .gate(pin), .shoot_cnt(shoot)
	);

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask

	// no fixed latency assumed: wait for pready, bounded
	task automatic apb(input logic w, input logic [7:0] idx,
		input logic [7:0] wd, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge pclk);
		paddr <= {2'b00, idx, 2'b00};
		pwrite <= w;
		pwdata <= {24'h0000_00, wd};
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// answer taken at the very edge that ends the access
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			give_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] d;
		logic e;
		apb(1'b1, idx, v, d, e);
	endtask

	task automatic unlock();
		wr(IDX_TA, TA_KEY1);
		wr(IDX_TA, TA_KEY2);
	endtask

	task automatic meas(input int b, input logic v, output int n);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (obs[b] !== v && n < 400);
		if (n >= 400) begin
			error_cnt++;
			give_verdict();
		end
	endtask

	task automatic go(input logic r, input int b, input logic v,
		output int n);
		repeat (12) @(posedge pclk);
		raw[0] <= r;
		meas(b, v, n);
	endtask

	task automatic t_regs();
		logic [7:0]  ids [7] = '{IDX_POL, IDX_BRK, IDX_CTL1, IDX_DTEN,
			IDX_DTCNT, IDX_MEN, IDX_MLV};
		logic [31:0] d;
		logic        e;
		foreach (ids[i]) begin
			apb(1'b0, ids[i], 8'h00, d, e);
			chk("reset value", {8'h00, REG_RST}, d[15:0]);
		end
		apb(1'b0, 8'h01, 8'h00, d, e);
		chk1("unmapped error", 1'b1, e);
		chk1("run at reset", 1'b0, run);
	endtask

	task automatic t_modes();
		logic [5:0] ex [4] = '{6'h0d, 6'h25, 6'h0f, 6'h0d};
		@(posedge pclk);
		raw <= 6'h0d;
		for (int m = 0; m < 4; m++) begin
			wr(IDX_CTL1, {m[1:0], 6'h00});
			repeat (2) @(negedge pclk);
			chk("mode field", 16'(m), 16'(ctl1.mode));
			chk("mode pins", 16'(ex[m]), 16'(pin));
		end
	endtask

	task automatic t_lock();
		logic [31:0] d;
		logic        e;
		wr(IDX_DTEN, 8'h17);
		apb(1'b0, IDX_DTEN, 8'h00, d, e);
		chk("locked write", 16'h0000, d[15:0]);
		unlock();
		wr(IDX_DTEN, 8'h17);
		apb(1'b0, IDX_DTEN, 8'h00, d, e);
		chk("open write", {8'h00, MASK_DTEN}, d[15:0]);
		wr(IDX_DTCNT, 8'h04);
		apb(1'b0, IDX_DTCNT, 8'h00, d, e);
		chk("window used", 16'h0000, d[15:0]);
	endtask

	task automatic t_mask();
		wr(IDX_CTL1, 8'h00);
		wr(IDX_MEN, 8'h0f);
		wr(IDX_MLV, 8'h05);
		wr(IDX_POL, 8'h03);
		repeat (2) @(negedge pclk);
		chk("masked pins", 16'h0006, 16'(pin));
	endtask

	task automatic t_dt();
		int          n;
		logic [15:0] s0;
		@(posedge pclk);
		raw <= 6'h00;
		wr(IDX_MEN, 8'h00);
		wr(IDX_POL, 8'h00);
		wr(IDX_CTL1, 8'h40);
		unlock();
		wr(IDX_DTEN, 8'h01);
		unlock();
		wr(IDX_DTCNT, 8'h04);
		s0 = shoot;
		go(1'b1, 0, 1'b1, n);
		chk1("rise held", 1'b1, n >= 5 && n <= 9);
		chk1("partner low", 1'b0, pin[1]);
		tick_slow <= 1'b1;
		go(1'b0, 1, 1'b1, n);
		tick_slow <= 1'b0;
		chk1("odd rise slow", 1'b1, n >= 11 && n <= 14);
		unlock();
		wr(IDX_DTEN, 8'h11);
		go(1'b1, 0, 1'b1, n);
		chk1("nine bit len", 1'b1, n >= 261 && n <= 265);
		go(1'b0, 1, 1'b1, n);
		chk1("nine bit odd", 1'b1, n >= 261 && n <= 265);
		chk("no overlap", s0, shoot);
		unlock();
		wr(IDX_DTEN, 8'h00);
		go(1'b1, 0, 1'b1, n);
		chk1("pair off", 1'b1, n <= 3);
		unlock();
		wr(IDX_DTEN, 8'h01);
		wr(IDX_CTL1, 8'h00);
		go(1'b0, 0, 1'b0, n);
		go(1'b1, 0, 1'b1, n);
		chk1("not compl", 1'b1, n <= 3);
	endtask

	task automatic t_adc();
		wr(IDX_MEN, 8'h0f);
		wr(IDX_MLV, 8'h05);
		wr(IDX_POL, 8'h03);
		wr(IDX_BRK, 8'h2a);
		wr(IDX_CTL0, 8'h80);
		@(posedge pclk);
		adc_ev <= 1'b1;
		@(posedge pclk);
		adc_ev <= 1'b0;
		@(negedge pclk);
		chk("brake pins", 16'h0029, 16'(pin));
		chk1("flag set", 1'b1, flag);
		chk1("run cleared", 1'b0, run);
		chk1("cnt reset", 1'b1, cnt_rst);
		chk("cnt value", 16'h0000, cnt_val);
		@(negedge pclk);
		chk1("cnt pulse", 1'b0, cnt_rst);
		wr(IDX_BRK, 8'h2a);
		@(negedge pclk);
		chk1("flag clear", 1'b0, flag);
		chk("brake held", 16'h0029, 16'(pin));
		wr(IDX_CTL0, 8'h80);
		repeat (2) @(negedge pclk);
		chk("resumed", 16'h0006, 16'(pin));
		chk1("released", 1'b0, brk);
	endtask

	task automatic t_pin();
		int n;
		wr(IDX_BRK, 8'h6a);
		@(posedge pclk);
		fb_pin <= 1'b1;
		repeat (20) @(negedge pclk);
		chk1("pin disabled", 1'b0, flag);
		@(posedge pclk);
		fb_pin <= 1'b0;
		wr(IDX_CTL1, 8'h08);
		repeat (20) @(posedge pclk);
		fb_pin <= 1'b1;
		repeat (5) @(posedge pclk);
		fb_pin <= 1'b0;
		repeat (20) @(negedge pclk);
		chk1("short pulse", 1'b0, flag);
		@(posedge pclk);
		fb_pin <= 1'b1;
		meas(NCH, 1'b1, n);
		chk1("rising fault", 1'b1, n >= 9 && n <= 16);
		@(negedge pclk);
		chk("pin brake", 16'h0029, 16'(pin));
		wr(IDX_BRK, 8'h2a);
		wr(IDX_CTL0, 8'h80);
		@(posedge pclk);
		fb_pin <= 1'b0;
		meas(NCH, 1'b1, n);
		chk1("falling fault", 1'b1, n >= 9 && n <= 16);
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_modes();
		t_lock();
		t_mask();
		t_dt();
		t_adc();
		t_pin();
		give_verdict();
	end
endmodule
